//--- core/cmo_pkg.sv
// Constants and types for the CAN message object register set
// How it works
// - Received length differing from stored length sets the length warning flag.
// - Every received frame overwrites the stored length code.
// - Transmit-done, receive-done and error flags can request an interrupt.
// - Transmit-done sets at the end of end-of-frame.
// - Lowest enabled transmit object index 0..14 is sent first.
// - Receive-done sets at the end of the sixth end-of-frame bit.
// - Only the lowest matching receive object is updated.
// - Bit error on sent/seen mismatch, except arbitration loss and ack slot.
// - Stuff error on more than five equal bits in stuffed fields.
// - CRC over de-stuffed frame start to data, mismatch flags error.
// - Form error on bad CRC delimiter, ack delimiter or end-of-frame.
// - Ack error when ack slot stays recessive while transmitting.
// - Config field: 00 off, 01 transmit, 10 receive, 11 buffer receive.
// - Config kept after completion; rewrite needed to clear done and to re-arm, except buffer receive, which stays armed.
// - Writing the config field updates that object's enable status bit.
// - Reply valid bit: 0 not ready, 1 automatic reply ready.
// - Extension bit selects 11 or 29 bit identifier, updated on receive.
// - Length codes above 8 act as 8 data bytes.
// - Standard identifier at tag bits 31:21, remote bit 2, reserved zero bit 0.
// - Standard tag bits 20:3 and 1 unused for match, overwritten on receive.
// - Extended identifier at tag bits 31:3, remote 2, reserved 1 and 0.
// - Object registers have no reset value; software initialises them.
package cmo_pkg;
  localparam int NOBJ = 15;
  // Byte addresses on the register port
  localparam logic [3:0] A_PAGE = 4'h0;
  localparam logic [3:0] A_STAT = 4'h1;
  localparam logic [3:0] A_CTL = 4'h2;
  localparam logic [3:0] A_TAG1 = 4'h3;
  localparam logic [3:0] A_TAG2 = 4'h4;
  localparam logic [3:0] A_TAG3 = 4'h5;
  localparam logic [3:0] A_TAG4 = 4'h6;
  localparam logic [3:0] A_ENL = 4'h7;
  localparam logic [3:0] A_ENH = 4'h8;
  localparam logic [7:0] PAGE_RST = 8'h00;
  // Status bit positions
  localparam int S_LENGTH_WARNING_FLAG = 7;
  localparam int S_TRANSMIT_DONE_FLAG = 6;
  localparam int S_RECEIVE_DONE_FLAG = 5;
  // Control register layout
  localparam int C_REPLY_VALID_BIT = 5;
  localparam int C_IDE = 4;
  localparam logic [1:0] CFG_DIS = 2'h0;
  localparam logic [1:0] CFG_TX = 2'h1;
  localparam logic [1:0] CFG_RX = 2'h2;
  localparam logic [1:0] CFG_FB = 2'h3;
  localparam logic [3:0] MAX_DLC = 4'h8;
  // Bit stream constants
  localparam logic [14:0] CRC_POLY = 15'h4599;
  localparam logic [2:0] STUFF_MAX = 3'h5;
  localparam logic [2:0] EOF_RX_IDX = 3'h5;
  localparam logic [2:0] EOF_TX_IDX = 3'h6;
  // Frame field being sampled
  typedef enum logic [3:0] {
    FLD_IDLE, FLD_ARB, FLD_DATA, FLD_CRC, FLD_CRC_DEL,
    FLD_ACK, FLD_ACK_DEL, FLD_EOF, FLD_ERR
  } cmo_fld_t;
endpackage : cmo_pkg

//--- core/cmo_regs.sv
// CAN message object registers with completion and error flagging
//
// The strobed register port and the placing of the registers were decided locally.
module cmo_regs
  import cmo_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Sampled bit stream from the bit timing logic
  input wire logic bit_tick,
  input wire logic rx_bit,
  input wire logic tx_bit,
  input wire logic sending,
  input wire cmo_fld_t field,
  // Received frame from the acceptance filter
  input wire logic [NOBJ-1:0] rx_hit,
  input wire logic [28:0] rx_id,
  input wire logic rx_ide,
  input wire logic rx_rtr,
  input wire logic rx_rb1,
  input wire logic rx_rb0,
  input wire logic [3:0] rx_dlc,
  // Frame to send
  output logic tx_req,
  output logic [3:0] tx_obj,
  output logic [31:0] tx_tag,
  output logic tx_ide,
  output logic [3:0] tx_dlc,
  // Flag event towards the interrupt controller
  output logic irq_evt,
  output logic [3:0] irq_obj
);

  // Lowest set index; bit 4 says one was found
  function automatic logic [4:0] lowest(input logic [NOBJ-1:0] v);
    logic [4:0] r;
    r = 5'h0f;
    for (int i = NOBJ - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : lowest

  logic [7:0] page_r;
  logic [NOBJ-1:0] en_r;
  logic [NOBJ-1:0] lock_r;
  logic [NOBJ-1:0] rpend_r;
  logic [7:0] stat_r [NOBJ];
  logic [7:0] ctl_r [NOBJ];
  logic [31:0] tag_r [NOBJ];
  logic [NOBJ-1:0] tx_elig;
  logic [NOBJ-1:0] rx_elig;
  logic [3:0] pg;
  logic pg_ok;
  logic [4:0] tx_pick;
  logic [4:0] rx_pick;
  // Bit stream state
  logic prev_r;
  logic [2:0] run_r;
  logic [14:0] crc_r;
  logic [14:0] rcrc_r;
  logic [2:0] eof_r;
  logic form_error_flag_frame_r;
  logic stuffed;
  logic is_stuff;
  logic e_bit, e_stuff, e_crc, e_form, e_ack;
  logic any_err;
  logic rx_done;
  logic tx_done;
  logic [3:0] err_obj;
  logic err_ok;
  logic [31:0] rx_tag;

  assign pg = page_r[7:4];
  assign pg_ok = pg < 4'(NOBJ);
  assign tx_pick = lowest(tx_elig);
  assign rx_pick = lowest(rx_elig);

  // Field classification and stuff bit position
  assign stuffed = field == FLD_ARB || field == FLD_DATA || field == FLD_CRC;
  assign is_stuff = stuffed && run_r == STUFF_MAX;

  // Error detectors, all qualified by the bit sample tick
  assign e_bit = bit_tick && sending && rx_bit != tx_bit
    && !(field == FLD_ARB && tx_bit) && field != FLD_ACK;
  assign e_stuff = bit_tick && is_stuff && rx_bit == prev_r;
  assign e_crc = bit_tick && field == FLD_CRC_DEL && crc_r != rcrc_r;
  assign e_form = bit_tick && !rx_bit && (field == FLD_CRC_DEL
    || field == FLD_ACK_DEL || field == FLD_EOF);
  assign e_ack = bit_tick && sending && field == FLD_ACK && rx_bit;
  assign any_err = e_bit | e_stuff | e_crc | e_form | e_ack;

  // Completion points inside end-of-frame, only for clean frames
  assign rx_done = bit_tick && field == FLD_EOF && eof_r == EOF_RX_IDX
    && !sending && !form_error_flag_frame_r && !any_err && rx_pick[4];
  assign tx_done = bit_tick && field == FLD_EOF && eof_r == EOF_TX_IDX
    && sending && !form_error_flag_frame_r && !any_err && tx_req;

  // Errors land in the object currently on the bus
  assign err_obj = sending ? tx_obj : rx_pick[3:0];
  assign err_ok = sending ? tx_req : rx_pick[4];

  // Received tag; standard frames leave id upper bits in the unused field
  assign rx_tag = rx_ide ? {rx_id, rx_rtr, rx_rb1, rx_rb0}
    : {rx_id[10:0], rx_id[28:11], rx_rtr, rx_rb1, rx_rb0};

  // Run length of equal bits for stuff handling
  always_ff @(posedge clk)
  begin
    if (sys_rst || field == FLD_IDLE)
    begin
      run_r <= 3'h0;
      prev_r <= 1'b1;
    end
    else if (bit_tick)
    begin
      prev_r <= rx_bit;
      if (!stuffed || rx_bit != prev_r)
        run_r <= 3'h1;
      else if (run_r != STUFF_MAX)
        run_r <= run_r + 3'h1;
    end
  end

  // CRC over de-stuffed start-of-frame through data, and received CRC
  always_ff @(posedge clk)
  begin
    if (sys_rst || field == FLD_IDLE)
    begin
      crc_r <= 15'h0000;
      rcrc_r <= 15'h0000;
    end
    else if (bit_tick && !is_stuff)
    begin
      if (field == FLD_ARB || field == FLD_DATA)
        crc_r <= {crc_r[13:0], 1'b0} ^ ((crc_r[14] ^ rx_bit) ? CRC_POLY : 15'h0000);
      if (field == FLD_CRC)
        rcrc_r <= {rcrc_r[13:0], rx_bit};
    end
  end

  // End-of-frame bit counter and per-frame error memory
  always_ff @(posedge clk)
  begin
    if (sys_rst || field == FLD_IDLE)
    begin
      eof_r <= 3'h0;
      form_error_flag_frame_r <= 1'b0;
    end
    else
    begin
      if (bit_tick && field == FLD_EOF && eof_r != 3'h7)
        eof_r <= eof_r + 3'h1;
      if (any_err)
        form_error_flag_frame_r <= 1'b1;
    end
  end

  // Page select
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      page_r <= PAGE_RST;
    else if (reg_wr && reg_addr == A_PAGE)
      page_r <= reg_wdata;
  end

  // Per-object storage; status, control and tags have no reset, software must initialise
  for (genvar o = 0; o < NOBJ; o++)
  begin : g_obj
    localparam logic [3:0] OI = 4'(o);
    logic sel;
    logic rx_me;
    logic tx_me;
    logic reply;
    logic [7:0] set;
    logic [7:0] sw;
    assign sel = pg_ok && pg == OI;
    assign rx_me = rx_done && rx_pick[3:0] == OI;
    assign tx_me = tx_done && tx_obj == OI;
    assign reply = rx_me && rx_rtr && ctl_r[o][C_REPLY_VALID_BIT];
    assign tx_elig[o] = en_r[o] && (ctl_r[o][7:6] == CFG_TX || rpend_r[o]);
    assign rx_elig[o] = rx_hit[o] && en_r[o]
      && (ctl_r[o][7:6] == CFG_RX || ctl_r[o][7:6] == CFG_FB);
    // Hardware set terms for this object
    always_comb
    begin
      set = 8'h00;
      if (err_ok && err_obj == OI)
        set[4:0] = {e_bit, e_stuff, e_crc, e_form, e_ack};
      set[S_TRANSMIT_DONE_FLAG] = tx_me;
      set[S_RECEIVE_DONE_FLAG] = rx_me;
      set[S_LENGTH_WARNING_FLAG] = rx_me && rx_dlc != ctl_r[o][3:0];
    end
    // Software write keeps done flags while the object is not re-armed
    always_comb
    begin
      sw = reg_wdata;
      if (lock_r[o])
        sw[S_TRANSMIT_DONE_FLAG:S_RECEIVE_DONE_FLAG] = stat_r[o][S_TRANSMIT_DONE_FLAG:S_RECEIVE_DONE_FLAG];
    end
    // Status: set wins over a simultaneous clear
    always_ff @(posedge clk)
    begin
      if (reg_wr && reg_addr == A_STAT && sel)
        stat_r[o] <= sw | set;
      else
        stat_r[o] <= stat_r[o] | set;
    end
    // Control and length; config bits never touched by hardware
    always_ff @(posedge clk)
    begin
      if (reg_wr && reg_addr == A_CTL && sel)
        ctl_r[o] <= reg_wdata;
      else if (rx_me)
        ctl_r[o] <= {ctl_r[o][7:5], rx_ide, rx_dlc};
      else if (tx_me && rpend_r[o])
        ctl_r[o][C_REPLY_VALID_BIT] <= 1'b0;
    end
    // Identifier tag bytes, refreshed on reception
    always_ff @(posedge clk)
    begin
      if (rx_me)
        tag_r[o] <= reply ? {rx_tag[31:3], 1'b0, rx_tag[1:0]} : rx_tag;
      else if (reg_wr && sel)
      begin
        if (reg_addr == A_TAG1)
          tag_r[o][31:24] <= reg_wdata;
        if (reg_addr == A_TAG2)
          tag_r[o][23:16] <= reg_wdata;
        if (reg_addr == A_TAG3)
          tag_r[o][15:8] <= reg_wdata;
        if (reg_addr == A_TAG4)
          tag_r[o][7:0] <= reg_wdata;
      end
    end
    // Enable status, done lock and pending automatic reply
    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        en_r[o] <= 1'b0;
        lock_r[o] <= 1'b0;
        rpend_r[o] <= 1'b0;
      end
      else if (reg_wr && reg_addr == A_CTL && sel)
      begin
        en_r[o] <= reg_wdata[7:6] != CFG_DIS;
        lock_r[o] <= 1'b0;
        rpend_r[o] <= 1'b0;
      end
      else if (tx_me)
      begin
        en_r[o] <= 1'b0;
        lock_r[o] <= 1'b1;
        rpend_r[o] <= 1'b0;
      end
      else if (rx_me)
      begin
        // Buffer receive stays armed; a reply keeps the slot for sending
        en_r[o] <= reply || ctl_r[o][7:6] == CFG_FB;
        lock_r[o] <= 1'b1;
        rpend_r[o] <= reply;
      end
    end
  end

  // Transmit selection, frozen while this block is sending a frame
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tx_req <= 1'b0;
      tx_obj <= 4'h0;
      tx_tag <= 32'h0000_0000;
      tx_ide <= 1'b0;
      tx_dlc <= 4'h0;
    end
    else if (tx_done)
      tx_req <= 1'b0;
    else if (!sending)
    begin
      tx_req <= tx_pick[4];
      if (tx_pick[4])
      begin
        tx_obj <= tx_pick[3:0];
        tx_tag <= tag_r[tx_pick[3:0]];
        tx_ide <= ctl_r[tx_pick[3:0]][C_IDE];
        // Codes above eight send eight bytes
        tx_dlc <= ctl_r[tx_pick[3:0]][3:0] > MAX_DLC ? MAX_DLC
          : ctl_r[tx_pick[3:0]][3:0];
      end
    end
  end

  // Flag event pulse for the interrupt controller
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irq_evt <= 1'b0;
      irq_obj <= 4'h0;
    end
    else
    begin
      irq_evt <= tx_done || rx_done || (any_err && err_ok);
      irq_obj <= tx_done ? tx_obj : rx_done ? rx_pick[3:0] : err_obj;
    end
  end

  // Read data, valid the cycle after the read strobe
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        A_PAGE: reg_rdata <= page_r;
        A_STAT: reg_rdata <= pg_ok ? stat_r[pg] : 8'h00;
        A_CTL: reg_rdata <= pg_ok ? ctl_r[pg] : 8'h00;
        A_TAG1: reg_rdata <= pg_ok ? tag_r[pg][31:24] : 8'h00;
        A_TAG2: reg_rdata <= pg_ok ? tag_r[pg][23:16] : 8'h00;
        A_TAG3: reg_rdata <= pg_ok ? tag_r[pg][15:8] : 8'h00;
        A_TAG4: reg_rdata <= pg_ok ? tag_r[pg][7:0] : 8'h00;
        A_ENL: reg_rdata <= en_r[7:0];
        A_ENH: reg_rdata <= {1'b0, en_r[14:8]};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule : cmo_regs

//--- tb/cmo_regs_props.sv
// Assertion checker for the message object register block
module cmo_regs_props
  import cmo_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Bit stream
  input wire logic bit_tick,
  input wire logic sending,
  input wire cmo_fld_t field,
  // Send side and events
  input wire logic tx_req,
  input wire logic [3:0] tx_obj,
  input wire logic [3:0] tx_dlc,
  input wire logic irq_evt
);
  logic [2:0] eof_n_r;
  logic evt_seen_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // End-of-frame ticks; idle restarts the count between frames
  always_ff @(posedge clk)
  begin
    if (sys_rst || field == FLD_IDLE)
      eof_n_r <= 3'h0;
    else if (bit_tick && field == FLD_EOF)
      eof_n_r <= eof_n_r + 3'h1;
  end

  // Any flag event inside a frame marks it as errored, so no completion
  always_ff @(posedge clk)
  begin
    if (sys_rst || field == FLD_IDLE)
      evt_seen_r <= 1'b0;
    else if (irq_evt)
      evt_seen_r <= 1'b1;
  end

  property p_rst_quiet;
    $fell(sys_rst) |-> !tx_req && !irq_evt && reg_rdata == 8'h00;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
  property p_dlc_clamp;
    tx_req |-> tx_dlc <= MAX_DLC;
  endproperty
  a_dlc_clamp: assert property (p_dlc_clamp) else $error("send length above 8");
  property p_obj_range;
    tx_req |-> tx_obj < 4'he + 4'h1;
  endproperty
  a_obj_range: assert property (p_obj_range) else $error("send object out of range");
  property p_obj_hold;
    tx_req && sending |=> !tx_req || $stable(tx_obj);
  endproperty
  a_obj_hold: assert property (p_obj_hold) else $error("object swapped mid frame");
  property p_no_grab;
    sending && !tx_req |=> !tx_req;
  endproperty
  a_no_grab: assert property (p_no_grab) else $error("object chosen mid frame");
  // Seventh end-of-frame tick closes the send
  property p_tx_done;
    tx_req && sending && bit_tick && field == FLD_EOF && eof_n_r == 3'h6 && !evt_seen_r
      |=> irq_evt ##[0:1] !tx_req;
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("send completion missed");
  property p_evt_cause;
    irq_evt |-> $past(bit_tick);
  endproperty
  a_evt_cause: assert property (p_evt_cause) else $error("event without bit tick");
  property p_unmapped;
    reg_rd && reg_addr > A_ENH |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  c_tx_done: cover property (tx_req ##1 !tx_req && irq_evt);
  c_evt: cover property (irq_evt && !sending);
  c_unmapped: cover property (reg_rd && reg_addr > A_ENH);
endmodule : cmo_regs_props

bind cmo_regs cmo_regs_props u_props (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bit_tick(bit_tick), .sending(sending),
  .field(field), .tx_req(tx_req), .tx_obj(tx_obj), .tx_dlc(tx_dlc), .irq_evt(irq_evt));

//--- tb/cmo_can_node.sv
// Far-side bus node model with a stand-in bit stream
module cmo_can_node
  import cmo_pkg::*;
(
  // Clock
  input wire logic clk,
  // Bit stream towards the block
  output logic bit_tick,
  output logic rx_bit,
  output logic tx_bit,
  output logic sending,
  output cmo_fld_t field
);
  logic [14:0] crc;
  logic last, tx_r, nack_r;
  int run;
  cmo_fld_t bad_r;

  // Released bus idles recessive
  initial
  begin
    bit_tick = 1'b0;
    rx_bit = 1'b1;
    tx_bit = 1'b1;
    sending = 1'b0;
    field = FLD_IDLE;
  end

  // One bit: wired-and of both nodes, optional corruption
  task automatic put(input cmo_fld_t f, input logic b);
    logic far;
    far = tx_r ? !(f == FLD_ACK && !nack_r) : b;
    field <= f;
    tx_bit <= tx_r ? b : 1'b1;
    rx_bit <= ((tx_r ? b : 1'b1) & far) ^ (f == bad_r);
    bit_tick <= 1'b1;
    @(posedge clk);
    bit_tick <= 1'b0;
    @(posedge clk);
  endtask : put

  // Stuffed bit; stuff bits stay out of the checksum
  task automatic sb(input cmo_fld_t f, input logic b);
    if (f != FLD_CRC)
      crc = {crc[13:0], 1'b0} ^ ((b ^ crc[14]) ? CRC_POLY : 15'h0000);
    put(f, b);
    run = (b == last) ? run + 1 : 1;
    last = b;
    if (run == 5)
    begin
      put(f, !b);
      last = !b;
      run = 1;
    end
  endtask : sb

  // Whole frame; bad names a field to corrupt, FLD_ERR for none
  task automatic frame(input logic tx, input logic nack, input cmo_fld_t bad,
    input logic [31:0] pl);
    logic [14:0] c;
    tx_r = tx;
    nack_r = nack;
    bad_r = bad;
    crc = 15'h0000;
    run = 0;
    last = 1'b1;
    sending <= tx;
    @(posedge clk);
    for (int i = 31; i >= 0; i--)
      sb(i > 19 ? FLD_ARB : FLD_DATA, pl[i]);
    c = crc;
    for (int i = 14; i >= 0; i--)
      sb(FLD_CRC, c[i]);
    put(FLD_CRC_DEL, 1'b1);
    // A sender leaves the slot recessive; as receiver we drive the acknowledge
    put(FLD_ACK, tx);
    put(FLD_ACK_DEL, 1'b1);
    repeat (7) put(FLD_EOF, 1'b1);
    sending <= 1'b0;
    repeat (3) put(FLD_IDLE, 1'b1);
  endtask : frame
endmodule : cmo_can_node

//--- tb/cmo_regs_tb.sv
// Self-checking bench for the message object register block
module cmo_regs_tb
  import cmo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] rd_v, reg_rdata;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic bit_tick, rx_bit, tx_bit, sending, tx_req, tx_ide, irq_evt;
  cmo_fld_t field;
  logic [NOBJ-1:0] rx_hit = 15'h0000;
  logic [28:0] rx_id = 29'h0;
  logic rx_ide = 1'b0;
  logic rx_rtr = 1'b0;
  logic rx_rb1 = 1'b0;
  logic rx_rb0 = 1'b0;
  logic [3:0] rx_dlc = 4'h0;
  logic [3:0] tx_obj, tx_dlc, irq_obj;
  logic [31:0] tx_tag, t;
  int error_cnt = 0;
  int checks_done = 0;

  cmo_regs DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bit_tick(bit_tick),
    .rx_bit(rx_bit), .tx_bit(tx_bit), .sending(sending), .field(field), .rx_hit(rx_hit),
    .rx_id(rx_id), .rx_ide(rx_ide), .rx_rtr(rx_rtr), .rx_rb1(rx_rb1), .rx_rb0(rx_rb0),
    .rx_dlc(rx_dlc), .tx_req(tx_req), .tx_obj(tx_obj), .tx_tag(tx_tag), .tx_ide(tx_ide),
    .tx_dlc(tx_dlc), .irq_evt(irq_evt), .irq_obj(irq_obj));
  cmo_can_node node (.clk(clk), .bit_tick(bit_tick), .rx_bit(rx_bit), .tx_bit(tx_bit),
    .sending(sending), .field(field));

  // 100 MHz clock
  always #5 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One strobe cycle, then a spare edge so strobes never double up
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk);
    rd_v = reg_rdata;
  endtask : bus

  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd_v, e);
  endtask : rc

  // Select object, clear status, random tags read back
  task automatic arm(input logic [3:0] n, input logic [7:0] ctl);
    logic [7:0] v;
    bus(1'b1, A_PAGE, {n, 4'h0});
    bus(1'b1, A_STAT, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      v = 8'($urandom);
      bus(1'b1, 4'(A_TAG1 + k), v);
      rc(4'(A_TAG1 + k), v);
    end
    bus(1'b1, A_CTL, ctl);
  endtask : arm

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  // Hang guard, far beyond the expected run
  initial
  begin
    #200us;
    error_cnt++;
    close_out();
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'h2c95));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rc(A_ENL, 8'h00);
    arm(4'h3, 8'h4a);
    arm(4'h1, 8'h4f);
    rc(A_ENL, 8'h0a);
    chk(tx_obj, 4'h1);
    chk(tx_dlc, 4'h8);
    chk(tx_ide, 1'b0);
    node.frame(1'b1, 1'b0, FLD_ERR, $urandom);
    bus(1'b1, A_PAGE, 8'h10);
    rc(A_STAT, 8'h40);
    rc(A_CTL, 8'h4f);
    rc(A_ENL, 8'h08);
    chk(tx_obj, 4'h3);
    node.frame(1'b1, 1'b1, FLD_ERR, $urandom);
    bus(1'b1, A_PAGE, 8'h30);
    bus(1'b0, A_STAT, 8'h00);
    chk(rd_v & 8'h01, 8'h01);
    bus(1'b1, A_CTL, 8'h43);
    bus(1'b1, A_STAT, 8'h00);
    node.frame(1'b1, 1'b0, FLD_DATA, $urandom);
    bus(1'b0, A_STAT, 8'h00);
    chk(rd_v & 8'h10, 8'h10);
    bus(1'b1, A_CTL, 8'h00);
    // Two receivers hit by one frame
    arm(4'h5, 8'h82);
    arm(4'h6, 8'hc4);
    rx_hit <= 15'h0060;
    rx_id <= 29'($urandom);
    rx_ide <= 1'b1;
    {rx_rtr, rx_rb1, rx_rb0} <= 3'($urandom);
    rx_dlc <= 4'($urandom_range(3, 15));
    node.frame(1'b0, 1'b0, FLD_ERR, $urandom);
    t = {rx_id, rx_rtr, rx_rb1, rx_rb0};
    bus(1'b1, A_PAGE, 8'h50);
    rc(A_STAT, 8'ha0);
    rc(A_CTL, {4'h9, rx_dlc});
    for (int k = 0; k < 4; k++)
      rc(4'(A_TAG1 + k), t[31 - 8 * k -: 8]);
    bus(1'b1, A_STAT, 8'h00);
    rc(A_STAT, 8'h20);
    bus(1'b1, A_CTL, 8'h82);
    bus(1'b1, A_STAT, 8'h00);
    rc(A_STAT, 8'h00);
    bus(1'b1, A_PAGE, 8'h60);
    rc(A_STAT, 8'h00);
    // Corrupted checksum, then corrupted delimiter
    node.frame(1'b0, 1'b0, FLD_CRC, $urandom);
    bus(1'b1, A_PAGE, 8'h50);
    bus(1'b0, A_STAT, 8'h00);
    chk(rd_v & 8'h24, 8'h04);
    bus(1'b1, A_STAT, 8'h00);
    node.frame(1'b0, 1'b0, FLD_CRC_DEL, $urandom);
    bus(1'b0, A_STAT, 8'h00);
    chk(rd_v & 8'h02, 8'h02);
    rc(A_ENL, 8'h60);
    arm(4'he, 8'h48);
    rc(A_ENH, 8'h40);
    chk(tx_obj, 4'he);
    bus(1'b1, A_PAGE, 8'hf0);
    rc(A_STAT, 8'h00);
    rc(4'h9, 8'h00);
    close_out();
  end
endmodule : cmo_regs_tb
